// ### tb/rlio_host.sv
// wishbone master model standing in for the host bridge
`timescale 1ns/1ps
module rlio_host
  import rlio_pkg::*;
(
  // clock
  input  wire logic         clk_i,
  // wishbone master side
  output rlio_wb_req_t      wb_o,
  input  wire rlio_wb_rsp_t wb_i
);
  // idle bus at time zero
  initial wb_o = '0;

  // one classic cycle; waits for ack with no count of its own
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] wd, output logic [31:0] rd);
    rlio_wb_req_t req;
    req = '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: wd};
    @(posedge clk_i);
    wb_o <= req;
    do @(posedge clk_i); while (wb_i.ack !== 1'b1);
    rd = wb_i.dat;
    // released lines show the inverse, never the old value
    req = ~req;
    req.cyc = 1'b0;
    req.stb = 1'b0;
    wb_o <= req;
  endtask
endmodule

// ### tb/tb_relay_output_input_irq_regs.sv
// self-checking bench for the relay, input and interrupt register block
`timescale 1ns/1ps
module tb_relay_output_input_irq_regs
  import rlio_pkg::*;
;
  // row: address, write data, expected readback
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] wd;
    logic [31:0] exp;
  } rlio_row_t;

  logic         clk_i;      // bench clock
  logic         rst_i;      // synchronous reset
  rlio_wb_req_t wb_req;     // host to slave
  rlio_wb_rsp_t wb_rsp;     // slave to host
  logic [1:0]   inp;        // isolated input levels
  logic [31:0]  relay;      // relay drives
  logic         irq;        // interrupt line
  logic [31:0]  rd;         // last read data
  int           error_cnt;  // mismatches
  int           checks;     // comparisons
  int           cycles = 0; // timeout counter
  rlio_row_t    rows [6] = '{
    '{8'h00, 32'hFFFF_A5C3, 32'h0000_A5C3},
    '{8'h08, 32'h0000_5A3C, 32'h0000_5A3C},
    '{8'h04, 32'h1234_5678, 32'h0000_0000},
    '{8'h10, 32'h0000_FFFF, 32'h0000_0000},
    '{8'h20, 32'h0000_0001, 32'h0000_0000},
    '{8'hFC, 32'hFFFF_FFFF, 32'h0000_0000}};

  rlio_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_req), .wb_o(wb_rsp),
    .isolated_input_bits_i(inp), .relay_drive_bit_o(relay), .irq_o(irq));
  rlio_host host (.clk_i(clk_i), .wb_o(wb_req), .wb_i(wb_rsp));

  // 50 ns clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // bus write
  task automatic wr(input logic [7:0] adr, input logic [31:0] d, input logic [3:0] sel);
    host.xfer(1'b1, adr, sel, d, rd);
  endtask

  // bus read and compare
  task automatic rdchk(input string nm, input logic [7:0] adr, input logic [31:0] exp);
    host.xfer(1'b0, adr, 4'hF, 32'h0000_0000, rd);
    chk(nm, exp, rd);
  endtask

  // let synchroniser and edge detector settle
  task automatic settle;
    repeat (5) @(posedge clk_i);
  endtask

  // report and end the run
  task automatic finish_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      finish_test();
    end
  end

  // main sequence
  initial begin
    error_cnt = 0;
    checks = 0;
    rst_i = 1'b1;
    inp = 2'b00;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("relay reset", 32'h0000_0000, relay);
    chk("irq reset", 32'h0000_0000, {31'h0, irq});
    rdchk("enable reset", 8'h30, 32'h0000_0000);
    rdchk("pending reset", 8'h34, 32'h0000_0000);
    // table of writes with readback
    foreach (rows[i]) begin
      wr(rows[i].adr, rows[i].wd, 4'hF);
      rdchk("table read", rows[i].adr, rows[i].exp);
    end
    chk("relay drive", 32'h5A3C_A5C3, relay);
    // one byte lane of group 1
    wr(8'h08, 32'h0000_FFFF, 4'b0001);
    rdchk("group1 lane", 8'h08, 32'h0000_5AFF);
    chk("relay lane", 32'h5AFF_A5C3, relay);
    // inputs rise while both sources are disabled
    inp <= 2'b11;
    settle();
    rdchk("inputs", 8'h10, 32'h0000_0003);
    rdchk("pending off", 8'h34, 32'h0000_0000);
    chk("irq off", 32'h0000_0000, {31'h0, irq});
    // source 0 only
    wr(8'h30, 32'h0000_0001, 4'b0001);
    inp <= 2'b00;
    settle();
    rdchk("falling", 8'h34, 32'h0000_0000);
    inp <= 2'b10;
    settle();
    rdchk("src1 disabled", 8'h34, 32'h0000_0000);
    rdchk("inputs mixed", 8'h10, 32'h0000_0002);
    inp <= 2'b11;
    settle();
    rdchk("src0 rise", 8'h34, 32'h0000_0001);
    chk("irq on", 32'h0000_0001, {31'h0, irq});
    repeat (20) @(posedge clk_i);
    rdchk("held", 8'h34, 32'h0000_0001);
    chk("irq held", 32'h0000_0001, {31'h0, irq});
    // clear with odd data and no lanes
    wr(8'h20, 32'hDEAD_BEEF, 4'h0);
    rdchk("cleared", 8'h34, 32'h0000_0000);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    // both sources
    wr(8'h30, 32'h0000_0003, 4'b0001);
    inp <= 2'b00;
    settle();
    inp <= 2'b11;
    settle();
    rdchk("both", 8'h34, 32'h0000_0003);
    wr(8'h34, 32'h0000_0001, 4'b0001);
    rdchk("w1c", 8'h34, 32'h0000_0002);
    chk("irq src1", 32'h0000_0001, {31'h0, irq});
    wr(8'h30, 32'h0000_0000, 4'b0001);
    rdchk("masked", 8'h34, 32'h0000_0002);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    wr(8'h20, 32'h0000_0000, 4'hF);
    rdchk("final clear", 8'h34, 32'h0000_0000);
    // mid-run reset with relays closed and a request pending
    wr(8'h30, 32'h0000_0001, 4'b0001);
    inp <= 2'b00;
    settle();
    inp <= 2'b01;
    settle();
    chk("irq before reset", 32'h0000_0001, {31'h0, irq});
    inp <= 2'b00;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("relay mid reset", 32'h0000_0000, relay);
    chk("irq mid reset", 32'h0000_0000, {31'h0, irq});
    rdchk("enable mid reset", 8'h30, 32'h0000_0000);
    rdchk("pending mid reset", 8'h34, 32'h0000_0000);
    rdchk("group0 mid reset", 8'h00, 32'h0000_0000);
    finish_test();
  end
endmodule

// ### verilog/rlio_consts.svh
// register indices, field positions and reset values of the relay/input block
`ifndef RLIO_CONSTS_SVH
`define RLIO_CONSTS_SVH

// word indices; byte address is four times the index
`define RLIO_IDX_GRP0    6'h00
`define RLIO_IDX_GRP1    6'h02
`define RLIO_IDX_INPUT   6'h04
`define RLIO_IDX_CLRIRQ  6'h08
`define RLIO_IDX_IRQEN   6'h0C
`define RLIO_IDX_IRQPEND 6'h0D

// field positions
`define RLIO_GRP1_LSB    16
`define RLIO_NUM_IN      2

// reset values
`define RLIO_RST_RELAY   32'h0000_0000
`define RLIO_RST_DATA    32'h0000_0000
`define RLIO_RST_IN      2'h0
`define RLIO_RST_IRQEN   2'h0
`define RLIO_RST_PEND    2'h0
`endif

// ### verilog/rlio_pkg.sv
// types shared by the relay/input register block
package rlio_pkg;
  // classic wishbone request from the bus master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } rlio_wb_req_t;

  // wishbone answer of the slave
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } rlio_wb_rsp_t;

  // complete state of the register block
  typedef struct packed {
    rlio_wb_rsp_t rsp;
    logic [31:0]  relay;
    logic [1:0]   in_meta;
    logic [1:0]   in_sync;
    logic [1:0]   in_prev;
    logic [1:0]   irq_enable;
    logic [1:0]   irq_pending;
    logic         irq;
  } rlio_state_t;
endpackage

// ### verilog/rlio_regs.sv
// relay output, isolated input and interrupt registers on a wishbone slave
`timescale 1ns/1ps
`include "rlio_consts.svh"

module rlio_regs
  import rlio_pkg::*;
(
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // wishbone slave
  input  wire rlio_wb_req_t wb_i,
  output rlio_wb_rsp_t      wb_o,
  // isolated inputs from the opto couplers
  input  wire logic [1:0]   isolated_input_bits_i,
  // relay drive and interrupt
  output logic [31:0]       relay_drive_bit_o,
  output logic              irq_o
);

  // reset image of the whole state
  localparam rlio_state_t RST_STATE = '{
    rsp:         '{ack: 1'b0, dat: `RLIO_RST_DATA},
    relay:       `RLIO_RST_RELAY,
    in_meta:     `RLIO_RST_IN,
    in_sync:     `RLIO_RST_IN,
    in_prev:     `RLIO_RST_IN,
    irq_enable:  `RLIO_RST_IRQEN,
    irq_pending: `RLIO_RST_PEND,
    irq:         1'b0
  };

  // address decode against a word index
  function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
    hit = (adr[7:2] == idx);
  endfunction

  rlio_state_t s_q;          // registered state
  rlio_state_t s_d;          // next state
  logic        acc;          // new access, first cycle only
  logic        wr;           // write access taking effect
  logic        rd;           // read access being answered
  logic [1:0]  rise;         // rising edge seen on synced inputs
  logic [1:0]  set_ev;       // enabled edge events
  logic        clr_all;      // write to the clear location
  logic [1:0]  clr_bits;     // one-to-clear write on status

  // access strobes: answer one cycle after the request
  assign acc      = wb_i.cyc & wb_i.stb & ~s_q.rsp.ack;
  assign wr       = acc & wb_i.we;
  assign rd       = acc & ~wb_i.we;

  // edge detection on the second sync stage only
  assign rise     = s_q.in_sync & ~s_q.in_prev;
  assign set_ev   = rise & s_q.irq_enable;

  // any data, any lanes: the location write clears all
  assign clr_all  = wr & hit(wb_i.adr, `RLIO_IDX_CLRIRQ);
  assign clr_bits = (wr & hit(wb_i.adr, `RLIO_IDX_IRQPEND) & wb_i.sel[0])
                    ? wb_i.dat[1:0] : 2'h0;

  // next-state logic
  always_comb begin
    s_d = s_q;
    // two-stage synchroniser, then edge history
    s_d.in_meta = isolated_input_bits_i;
    s_d.in_sync = s_q.in_meta;
    s_d.in_prev = s_q.in_sync;

    // ack pulses for one cycle per request
    s_d.rsp.ack = acc;
    s_d.rsp.dat = `RLIO_RST_DATA;

    // register writes
    if (wr) begin
      // group 0 holds channels 1..16
      if (hit(wb_i.adr, `RLIO_IDX_GRP0)) begin
        if (wb_i.sel[0]) begin
          s_d.relay[7:0] = wb_i.dat[7:0];
        end
        if (wb_i.sel[1]) begin
          s_d.relay[15:8] = wb_i.dat[15:8];
        end
      end
      // group 1 holds channels 17..32
      if (hit(wb_i.adr, `RLIO_IDX_GRP1)) begin
        if (wb_i.sel[0]) begin
          s_d.relay[`RLIO_GRP1_LSB +: 8] = wb_i.dat[7:0];
        end
        if (wb_i.sel[1]) begin
          s_d.relay[`RLIO_GRP1_LSB + 8 +: 8] = wb_i.dat[15:8];
        end
      end
      // per-input interrupt enables
      if (hit(wb_i.adr, `RLIO_IDX_IRQEN) && wb_i.sel[0]) begin
        s_d.irq_enable = wb_i.dat[1:0];
      end
    end

    // register reads; unmapped reads return zero
    if (rd) begin
      case (wb_i.adr[7:2])
        // readback is the drive register: 1 closed, 0 open
        `RLIO_IDX_GRP0: begin
          s_d.rsp.dat = {16'h0000, s_q.relay[15:0]};
        end
        `RLIO_IDX_GRP1: begin
          s_d.rsp.dat = {16'h0000, s_q.relay[31:16]};
        end
        // only two low bits meaningful, rest zero
        `RLIO_IDX_INPUT: begin
          s_d.rsp.dat = {30'h0000_0000, s_q.in_sync};
        end
        `RLIO_IDX_IRQEN: begin
          s_d.rsp.dat = {30'h0000_0000, s_q.irq_enable};
        end
        `RLIO_IDX_IRQPEND: begin
          s_d.rsp.dat = {30'h0000_0000, s_q.irq_pending};
        end
        default: begin
          s_d.rsp.dat = `RLIO_RST_DATA;
        end
      endcase
    end

    // sticky pending bits: set wins over any clear
    for (int i = 0; i < `RLIO_NUM_IN; i++) begin
      if (set_ev[i]) begin
        s_d.irq_pending[i] = 1'b1;
      end else if (clr_all || clr_bits[i]) begin
        s_d.irq_pending[i] = 1'b0;
      end else begin
        s_d.irq_pending[i] = s_q.irq_pending[i];
      end
    end

    // level interrupt from unmasked pending sources
    s_d.irq = |(s_d.irq_pending & s_d.irq_enable);
  end

  // state register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign wb_o              = s_q.rsp;
  assign relay_drive_bit_o = s_q.relay;
  assign irq_o             = s_q.irq;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // helper: write decodes for the checks
  logic wr_g0;      // full-lane group 0 write
  logic wr_g1;      // full-lane group 1 write
  logic wr_en;      // enable write
  assign wr_g0 = wr & hit(wb_i.adr, `RLIO_IDX_GRP0) & (wb_i.sel[1:0] == 2'h3);
  assign wr_g1 = wr & hit(wb_i.adr, `RLIO_IDX_GRP1) & (wb_i.sel[1:0] == 2'h3);
  assign wr_en = wr & hit(wb_i.adr, `RLIO_IDX_IRQEN) & wb_i.sel[0];

  // helper: read decodes for the checks
  logic rd_g0;      // group 0 readback
  logic rd_g1;      // group 1 readback
  logic rd_clr;     // read of the write-only clear location
  assign rd_g0  = rd & hit(wb_i.adr, `RLIO_IDX_GRP0);
  assign rd_g1  = rd & hit(wb_i.adr, `RLIO_IDX_GRP1);
  assign rd_clr = rd & hit(wb_i.adr, `RLIO_IDX_CLRIRQ);

  // one ack per request, one cycle late, then dropped
  property p_ack_pulse;
    acc |=> wb_o.ack ##1 !wb_o.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack not a single delayed pulse");

  // group 0 write lands in channels 1..16 only
  property p_grp0_write;
    wr_g0 |=> (relay_drive_bit_o[15:0] == $past(wb_i.dat[15:0]))
      && (relay_drive_bit_o[31:16] == $past(relay_drive_bit_o[31:16]));
  endproperty
  a_grp0_write: assert property (p_grp0_write)
    else $error("group 0 write misplaced");

  // group 1 write lands in channels 17..32 only
  property p_grp1_write;
    wr_g1 |=> (relay_drive_bit_o[31:16] == $past(wb_i.dat[15:0]))
      && (relay_drive_bit_o[15:0] == $past(relay_drive_bit_o[15:0]));
  endproperty
  a_grp1_write: assert property (p_grp1_write)
    else $error("group 1 write misplaced");

  // group 0 readback returns the relays as driven
  property p_readback;
    rd_g0 |=> wb_o.dat == {16'h0000, $past(relay_drive_bit_o[15:0])};
  endproperty
  a_readback: assert property (p_readback)
    else $error("relay readback differs from drive");

  // group 1 readback returns channels 17..32 as driven
  property p_readback1;
    rd_g1 |=> wb_o.dat == {16'h0000, $past(relay_drive_bit_o[31:16])};
  endproperty
  a_readback1: assert property (p_readback1)
    else $error("group 1 readback differs from drive");

  // input read: synced bits low, upper bits zero
  property p_input_read;
    (rd && hit(wb_i.adr, `RLIO_IDX_INPUT))
      |=> wb_o.dat == {30'h0000_0000, $past(s_q.in_sync)};
  endproperty
  a_input_read: assert property (p_input_read)
    else $error("input read wrong");

  // input pin level reaches the readable bits in two cycles
  property p_input_sync;
    ##2 ($past(rst_i, 2) || (s_q.in_sync == $past(isolated_input_bits_i, 2)));
  endproperty
  a_input_sync: assert property (p_input_sync)
    else $error("input synchroniser delay wrong");

  // enable write steers the enables
  property p_enable_write;
    wr_en |=> s_q.irq_enable == $past(wb_i.dat[1:0]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("interrupt enable not written");

  // enabled rising edge sets pending next cycle, irq rises in the same cycle
  property p_rise_sets;
    (set_ev[0] && !wr_en) |=> s_q.irq_pending[0] && irq_o;
  endproperty
  a_rise_sets: assert property (p_rise_sets)
    else $error("enabled edge did not raise request");

  // without an enabled edge a clear source stays clear
  property p_no_spurious;
    (!s_q.irq_pending[1] && !set_ev[1]) |=> !s_q.irq_pending[1];
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("pending set without enabled edge");

  // clear location write empties pending unless new edge
  property p_clear;
    (clr_all && !(|set_ev)) |=> (s_q.irq_pending == 2'h0) && !irq_o;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not drop request");

  // pending holds until cleared
  property p_hold;
    (s_q.irq_pending[0] && !clr_all && !clr_bits[0])
      |=> s_q.irq_pending[0];
  endproperty
  a_hold: assert property (p_hold)
    else $error("pending dropped without clear");

  // status read reports pending bits
  property p_status_read;
    (rd && hit(wb_i.adr, `RLIO_IDX_IRQPEND))
      |=> wb_o.dat[1:0] == $past(s_q.irq_pending);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read wrong");

  // interrupt line matches masked pending
  property p_irq_line;
    irq_o == |(s_q.irq_pending & s_q.irq_enable);
  endproperty
  a_irq_line: assert property (p_irq_line)
    else $error("irq line disagrees with status");

  // ack only answers a request taken the cycle before
  property p_ack_needs_req;
    !acc |=> !wb_o.ack;
  endproperty
  a_ack_needs_req: assert property (p_ack_needs_req)
    else $error("ack without a request");

  // read data is zero whenever no ack stands
  property p_dat_idle;
    !wb_o.ack |-> wb_o.dat == `RLIO_RST_DATA;
  endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data not zero outside ack");

  // the clear location is write-only and reads as zero
  property p_clear_reads_zero;
    rd_clr |=> wb_o.dat == `RLIO_RST_DATA;
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero)
    else $error("clear location read not zero");

  // relays move only on a write access
  property p_relay_steady;
    !wr |=> $stable(relay_drive_bit_o);
  endproperty
  a_relay_steady: assert property (p_relay_steady)
    else $error("relay drive changed without a write");

  // source 0 pending rises only after an enabled rising input
  property p_rise_only;
    $rose(s_q.irq_pending[0])
      |-> $past(s_q.in_sync[0] && !s_q.in_prev[0] && s_q.irq_enable[0]);
  endproperty
  a_rise_only: assert property (p_rise_only)
    else $error("pending set without an enabled rising edge");

  // a disabled source never becomes pending
  property p_disabled_quiet;
    $rose(s_q.irq_pending[1]) |-> $past(s_q.irq_enable[1]);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("disabled source became pending");

  // one-to-clear write drops only the selected source
  property p_w1c;
    (clr_bits == 2'h1 && !clr_all && !(|set_ev))
      |=> !s_q.irq_pending[0] && (s_q.irq_pending[1] == $past(s_q.irq_pending[1]));
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("one-to-clear write hit the wrong source");

  // enable read returns the enables in the low bits
  property p_enable_read;
    (rd && hit(wb_i.adr, `RLIO_IDX_IRQEN))
      |=> wb_o.dat == {30'h0000_0000, $past(s_q.irq_enable)};
  endproperty
  a_enable_read: assert property (p_enable_read)
    else $error("enable read wrong");

  // main scenarios
  c_irq_raise: cover property (set_ev[0] ##1 irq_o);
  c_irq_clear: cover property (irq_o ##1 clr_all ##1 !irq_o);
  c_relay_rb:  cover property (wr_g1 ##[2:4] rd_g1);
  c_w1c:       cover property (clr_bits[0] ##1 (s_q.irq_pending == 2'h2));
  c_both_src:  cover property (s_q.irq_pending == 2'h3);

endmodule
